// ===== sti_pkg.sv
// shared constants and carrier types for the spi transfer integrity check
// assumes 16-bit spi words, command word = r/w bit, 7-bit address, 8 spare
package sti_pkg;

  // ----------------------------------------------------------------
  // word and command layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int CMD_RW_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DIAG_SPI_ERR_BIT = 3;
  localparam logic [3:0] BIT_LAST = 4'hF;

  // ----------------------------------------------------------------
  // register map, byte address of the even half of each pair
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_DIAG = 7'h02;
  localparam logic [6:0] ADDR_RATE_LOW0 = 7'h04;
  localparam logic [6:0] ADDR_ACCEL_LOW0 = 7'h10;
  localparam logic [6:0] ADDR_AXIS_STEP = 7'h04;
  localparam logic [6:0] ADDR_HIGH_OFS = 7'h02;
  localparam logic [6:0] ADDR_FILL = 7'h1C;
  localparam logic [6:0] ADDR_SUM = 7'h3E;
  localparam logic [6:0] ADDR_BURST = 7'h68;

  // ----------------------------------------------------------------
  // burst word order: diag, rate x/y/z hi-lo, accel x/y/z hi-lo,
  // fill count, checksum
  // ----------------------------------------------------------------
  localparam logic [3:0] BURST_RATE0 = 4'h1;
  localparam logic [3:0] BURST_ACCEL0 = 4'h7;
  localparam logic [3:0] BURST_CNT_IDX = 4'hD;
  localparam logic [3:0] BURST_LAST_IDX = 4'hE;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic PIN_IDLE_HIGH = 1'b1;

  typedef logic [2:0][31:0] sti_axes_t;

  typedef struct packed {
    sti_axes_t rate;
    sti_axes_t accel;
    logic [15:0] fill;
  } sti_sample_s;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic din_s1;
    logic din_s2;
    logic [3:0] bit_cnt;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [15:0] tx_cur;
    logic tx_counts;
    logic tx_clears_err;
    logic burst_on;
    logic [3:0] burst_idx;
    logic [15:0] ck;
    logic [15:0] sum;
    logic spi_err;
    sti_sample_s snap;
  } sti_state_s;

endpackage : sti_pkg

// ===== sti_byte_sum.sv
// byte-wise accumulator step: adds both bytes of a word, modulo 2^width
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
`default_nettype none

module sti_byte_sum #(
  parameter int WORD_W = sti_pkg::WORD_W
) (
  input wire logic [WORD_W-1:0] acc_in,
  input wire logic [WORD_W-1:0] word_in,
  output logic [WORD_W-1:0] acc_out
);
  import sti_pkg::*;

  // ----------------------------------------------------------------
  // sum of high and low byte, carries out of the top are dropped
  // ----------------------------------------------------------------
  localparam int HALF = WORD_W / 2;
  logic [WORD_W-1:0] hi_byte;
  logic [WORD_W-1:0] lo_byte;

  // zero-extend each byte so the add stays at word width
  assign hi_byte = {{HALF{1'b0}}, word_in[WORD_W-1:HALF]};
  assign lo_byte = {{HALF{1'b0}}, word_in[HALF-1:0]};
  assign acc_out = acc_in + hi_byte + lo_byte;

endmodule : sti_byte_sum

`default_nettype wire

// ===== sti_transfer_check.sv
// spi slave with transfer integrity checks: framing error flag, burst
// checksum, per-period running byte sum, split 32-bit axis registers
// assumes spi mode 3 from the host, sclk well below ref_clk / 8
`timescale 1ns/1ps
`default_nettype none

module sti_transfer_check (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  output logic spi_dout,
  output logic spi_dout_oe_n,
  input wire logic sample_tick,
  input wire sti_pkg::sti_sample_s sample_in,
  input wire logic [15:0] diag_flags_in,
  output logic spi_error_flag
);
  import sti_pkg::*;

  // ----------------------------------------------------------------
  // state and decoded events
  // ----------------------------------------------------------------
  sti_state_s s;
  sti_state_s n;
  logic rise;
  logic cs_fall;
  logic cs_rise;
  logic word_end;
  logic err_evt;
  logic count_word;
  logic [15:0] rx_word;
  logic [15:0] diag_word;
  logic [15:0] sum_base;
  logic [15:0] sum_add;
  logic [15:0] ck_add;

  // edges come from the second sync stage and its delayed copy only
  assign rise = s.sclk_s2 & ~s.sclk_d & ~s.cs_s2;
  assign cs_fall = ~s.cs_s2 & s.cs_d;
  assign cs_rise = s.cs_s2 & ~s.cs_d;
  assign word_end = rise && (s.bit_cnt == BIT_LAST);
  assign err_evt = cs_rise && (s.bit_cnt != 4'h0);
  assign count_word = word_end && s.tx_counts;
  assign rx_word = {s.rx_shift[14:0], s.din_s2};
  assign sum_base = sample_tick ? WORD_RST : s.sum;

  // diagnostic word: external flags with our error bit merged in
  always_comb begin
    diag_word = diag_flags_in;
    diag_word[DIAG_SPI_ERR_BIT] = s.spi_err;
  end

  // ----------------------------------------------------------------
  // byte-wise adders for running sum and burst checksum
  // ----------------------------------------------------------------
  sti_byte_sum #(.WORD_W(WORD_W)) u_sum_add (
    .acc_in(sum_base),
    .word_in(s.tx_cur),
    .acc_out(sum_add)
  );

  sti_byte_sum #(.WORD_W(WORD_W)) u_ck_add (
    .acc_in(s.ck),
    .word_in(s.tx_cur),
    .acc_out(ck_add)
  );

  // ----------------------------------------------------------------
  // register and burst word lookup
  // ----------------------------------------------------------------
  // returns {hit, data}; axes sit in pairs of low then high word
  function automatic logic [16:0] reg_word(input logic [6:0] addr,
                                           input sti_sample_s smp,
                                           input logic [15:0] dg,
                                           input logic [15:0] sm);
    logic [16:0] r;
    logic [6:0] lo_r;
    logic [6:0] lo_a;
    r = {1'b0, WORD_RST};
    if (addr == ADDR_DIAG) r = {1'b1, dg};
    if (addr == ADDR_FILL) r = {1'b1, smp.fill};
    if (addr == ADDR_SUM) r = {1'b1, sm};
    for (int a = 0; a < 3; a++) begin
      lo_r = ADDR_RATE_LOW0 + 7'(a) * ADDR_AXIS_STEP;
      lo_a = ADDR_ACCEL_LOW0 + 7'(a) * ADDR_AXIS_STEP;
      if (addr == lo_r) r = {1'b1, smp.rate[a][15:0]};
      if (addr == lo_r + ADDR_HIGH_OFS) r = {1'b1, smp.rate[a][31:16]};
      if (addr == lo_a) r = {1'b1, smp.accel[a][15:0]};
      if (addr == lo_a + ADDR_HIGH_OFS) r = {1'b1, smp.accel[a][31:16]};
    end
    return r;
  endfunction : reg_word

  // burst stream word by index; checksum goes last
  function automatic logic [15:0] burst_word(input logic [3:0] idx,
                                             input sti_sample_s smp,
                                             input logic [15:0] dg,
                                             input logic [15:0] ckv);
    logic [3:0] k;
    logic [31:0] v;
    burst_word = WORD_RST;
    if (idx == 4'h0) burst_word = dg;
    if (idx >= BURST_RATE0 && idx < BURST_CNT_IDX) begin
      k = (idx < BURST_ACCEL0) ? idx - BURST_RATE0 : idx - BURST_ACCEL0;
      v = (idx < BURST_ACCEL0) ? smp.rate[k[2:1]] : smp.accel[k[2:1]];
      burst_word = k[0] ? v[15:0] : v[31:16];
    end
    if (idx == BURST_CNT_IDX) burst_word = smp.fill;
    if (idx == BURST_LAST_IDX) burst_word = ckv;
  endfunction : burst_word

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [16:0] rw;
    logic [15:0] nxt;
    logic [3:0] nidx;
    rw = {1'b0, WORD_RST};
    nxt = WORD_RST;
    nidx = s.burst_idx + 4'h1;
    n = s;
    // pins pass two flops before any logic reads them
    n.sclk_s1 = spi_sclk;
    n.sclk_s2 = s.sclk_s1;
    n.sclk_d = s.sclk_s2;
    n.cs_s1 = spi_cs_n;
    n.cs_s2 = s.cs_s1;
    n.cs_d = s.cs_s2;
    n.din_s1 = spi_din;
    n.din_s2 = s.din_s1;
    // snapshot frozen during a burst so the stream stays coherent
    if (sample_tick && !s.burst_on) n.snap = sample_in;
    // running sum: restart on the tick, add bytes of each sent word except sum answers and the burst checksum
    n.sum = count_word ? sum_add : sum_base;
    if (cs_fall) n.bit_cnt = 4'h0;
    if (rise) begin
      n.rx_shift = rx_word;
      n.bit_cnt = s.bit_cnt + 4'h1;
      n.tx_shift = {s.tx_shift[14:0], 1'b0};
    end
    if (word_end) begin
      if (s.burst_on) begin
        // fill count word is left out of the checksum
        if (s.burst_idx != BURST_CNT_IDX) n.ck = ck_add;
        n.burst_on = (s.burst_idx != BURST_LAST_IDX);
        n.burst_idx = nidx;
        if (s.burst_idx != BURST_LAST_IDX) begin
          nxt = burst_word(nidx, s.snap, diag_word, s.ck);
        end
        n.tx_counts = n.burst_on && (nidx != BURST_LAST_IDX);
        n.tx_clears_err = 1'b0;
      end else if (!rx_word[CMD_RW_BIT] &&
                   rx_word[ADDR_MSB:ADDR_LSB] == ADDR_BURST) begin
        n.burst_on = 1'b1;
        n.burst_idx = 4'h0;
        n.ck = WORD_RST;
        nxt = burst_word(4'h0, s.snap, diag_word, WORD_RST);
        n.tx_counts = 1'b1;
        n.tx_clears_err = 1'b1;
      end else begin
        // writes hit nothing here; the answer to a read comes next word
        // sum read takes the updated sum, so the word that finishes
        // with the sum command is already in it
        if (!rx_word[CMD_RW_BIT]) begin
          rw = reg_word(rx_word[ADDR_MSB:ADDR_LSB], s.snap, diag_word,
                        n.sum);
        end
        nxt = rw[15:0];
        n.tx_counts = rw[16] &&
                      (rx_word[ADDR_MSB:ADDR_LSB] != ADDR_SUM);
        n.tx_clears_err = rw[16] &&
                          (rx_word[ADDR_MSB:ADDR_LSB] == ADDR_DIAG);
      end
      n.tx_shift = nxt;
      n.tx_cur = nxt;
    end
    // a burst ends with its frame; leftovers are not sent later
    if (cs_rise && s.burst_on) begin
      n.burst_on = 1'b0;
      n.tx_shift = WORD_RST;
      n.tx_cur = WORD_RST;
      n.tx_counts = 1'b0;
      n.tx_clears_err = 1'b0;
    end
    // set wins over the clear caused by reading the diagnostic word
    if (word_end && s.tx_clears_err) n.spi_err = 1'b0;
    if (err_evt) n.spi_err = 1'b1;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.sclk_s1 <= PIN_IDLE_HIGH;
      s.sclk_s2 <= PIN_IDLE_HIGH;
      s.sclk_d <= PIN_IDLE_HIGH;
      s.cs_s1 <= PIN_IDLE_HIGH;
      s.cs_s2 <= PIN_IDLE_HIGH;
      s.cs_d <= PIN_IDLE_HIGH;
    end else begin
      s <= n;
    end
  end

  // outputs straight from flops
  assign spi_dout = s.tx_shift[15];
  assign spi_dout_oe_n = s.cs_s2;
  assign spi_error_flag = s.spi_err;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic rd_cmd;
  assign rd_cmd = word_end && !s.burst_on && !rx_word[CMD_RW_BIT];

  property p_err_set;
    err_evt |=> s.spi_err ##1 spi_error_flag;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("framing error did not raise the spi error bit");

  property p_ck_last;
    word_end && s.burst_on && s.burst_idx == BURST_CNT_IDX
      |=> s.tx_cur == $past(s.ck) && s.burst_idx == BURST_LAST_IDX;
  endproperty
  a_ck_last: assert property (p_ck_last)
    else $error("checksum was not the last burst word");

  property p_ck_skip_fill;
    word_end && s.burst_on && s.burst_idx == BURST_CNT_IDX
      |=> $stable(s.ck);
  endproperty
  a_ck_skip_fill: assert property (p_ck_skip_fill)
    else $error("fill count word entered the burst checksum");

  property p_sum_read;
    rd_cmd && rx_word[ADDR_MSB:ADDR_LSB] == ADDR_SUM
      |=> s.tx_cur == s.sum && !s.tx_counts;
  endproperty
  a_sum_read: assert property (p_sum_read)
    else $error("running sum read returned a wrong value");

  property p_sum_add;
    count_word && !sample_tick |=> s.sum == 16'($past(s.sum) +
      $past(s.tx_cur[15:8]) + $past(s.tx_cur[7:0]));
  endproperty
  a_sum_add: assert property (p_sum_add)
    else $error("running sum did not add the sent bytes");

  property p_sum_clear;
    sample_tick && !count_word |=> s.sum == WORD_RST;
  endproperty
  a_sum_clear: assert property (p_sum_clear)
    else $error("running sum did not restart on the period tick");

  property p_rate_high;
    rd_cmd && rx_word[ADDR_MSB:ADDR_LSB] == ADDR_RATE_LOW0 + ADDR_HIGH_OFS
      |=> s.tx_cur == $past(s.snap.rate[0][31:16]);
  endproperty
  a_rate_high: assert property (p_rate_high)
    else $error("rate x high word mismatch");

  property p_accel_low;
    rd_cmd && rx_word[ADDR_MSB:ADDR_LSB] ==
      ADDR_ACCEL_LOW0 + ADDR_AXIS_STEP + ADDR_AXIS_STEP
      |=> s.tx_cur == $past(s.snap.accel[2][15:0]);
  endproperty
  a_accel_low: assert property (p_accel_low)
    else $error("accel z low word mismatch");

  c_burst_done: cover property (word_end && s.burst_on &&
                                s.burst_idx == BURST_LAST_IDX);
  c_frame_err: cover property (err_evt);
  c_sum_read: cover property (rd_cmd &&
                              rx_word[ADDR_MSB:ADDR_LSB] == ADDR_SUM);

endmodule : sti_transfer_check

`default_nettype wire

// ===== sti_host_model.sv
// host side of the serial link: spi master, mode 3, nbits bits per shift call
// assumes the device samples pins through synchronisers on ref_clk
`timescale 1ns/1ps
`default_nettype none

module sti_host_model (
  input wire logic ref_clk,
  input wire logic spi_dout,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_din
);
  import sti_pkg::*;

  // half period in ref_clk cycles, kept above the five-cycle minimum
  localparam int HALF = 6;

  // idle: clock high, deselected
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_din = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame control and bit shifting, all on ref_clk falling edges
  // ----------------------------------------------------------------
  task automatic select(input logic on);
    repeat (HALF) @(negedge ref_clk);
    spi_cs_n = ~on;
    spi_din = ~spi_din; // no stale level left on the line
    repeat (HALF) @(negedge ref_clk);
  endtask : select

  // data out on the falling clock, device answer taken before the rise
  task automatic shift(input int nbits, input logic [15:0] w,
                       output logic [15:0] r);
    r = 16'h0000;
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = 1'b0;
      spi_din = w[15 - i];
      repeat (HALF) @(negedge ref_clk);
      r = {r[14:0], spi_dout};
      spi_sclk = 1'b1;
      repeat (HALF) @(negedge ref_clk);
    end
  endtask : shift
endmodule : sti_host_model
`default_nettype wire

// ===== sti_testbench.sv
// self-checking bench for the transfer integrity block
// assumes sti_host_model drives the link; sums worked out here
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import sti_pkg::*;

  logic ref_clk, reset, spi_sclk, spi_cs_n, spi_din, spi_dout;
  logic spi_dout_oe_n, sample_tick, spi_error_flag;
  sti_sample_s sample_in;
  logic [15:0] diag_flags_in, rx, acc;
  logic [31:0] w;
  int n_mismatch = 0;
  int n_tests = 0;

  sti_transfer_check sti_transfer_check_inst (
    .ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
    .spi_dout_oe_n(spi_dout_oe_n), .sample_tick(sample_tick),
    .sample_in(sample_in), .diag_flags_in(diag_flags_in),
    .spi_error_flag(spi_error_flag));

  sti_host_model sti_host_model_inst (
    .ref_clk(ref_clk), .spi_dout(spi_dout), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_din(spi_din));

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-wise sum, 16-bit wrap comes from the width
  function automatic logic [15:0] bsum(input logic [15:0] a, x);
    return a + {8'h00, x[15:8]} + {8'h00, x[7:0]};
  endfunction : bsum

  // axis word i (even low, odd high): {read command, expected data}
  function automatic logic [31:0] ax(input int i);
    int k;
    logic [31:0] v;
    logic [6:0] a;
    k = i / 2;
    v = (k < 3) ? sample_in.rate[k % 3] : sample_in.accel[k % 3];
    a = ((k < 3) ? ADDR_RATE_LOW0 : ADDR_ACCEL_LOW0)
        + 7'(k % 3) * ADDR_AXIS_STEP;
    if (i % 2 == 1) begin
      return {1'b0, a + ADDR_HIGH_OFS, 8'h00, v[31:16]};
    end
    return {1'b0, a, 8'h00, v[15:0]};
  endfunction : ax

  task automatic chk16(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  task automatic xf(input logic [15:0] c);
    sti_host_model_inst.shift(16, c, rx);
  endtask : xf

  // period start while deselected; host sum restarts with it
  task automatic tick();
    sample_tick = 1'b1;
    @(negedge ref_clk);
    sample_tick = 1'b0;
    acc = 16'h0000;
  endtask : tick

  // pipelined: command word, then a write word carries the answer
  task automatic read_sum(input logic [15:0] e);
    xf({1'b0, ADDR_SUM, 8'h00});
    xf(16'h8000);
    chk16(rx, e);
  endtask : read_sum

  // sample inputs from one base value; the period tick latches them
  task automatic set_sample(input logic [31:0] b, input logic [15:0] dg);
    for (int i = 0; i < 3; i++) begin
      sample_in.rate[i] = b + 32'(i) * 32'h0101_0101;
      sample_in.accel[i] = (b ^ 32'h7070_7070) + 32'(i) * 32'h0101_0101;
    end
    sample_in.fill = b[31:16] ^ 16'h0123;
    diag_flags_in = dg;
  endtask : set_sample

  // burst in an open frame: diag, axes high then low, fill, checksum
  task automatic burst_check(input logic err);
    logic [15:0] e [0:14];
    logic [31:0] v;
    e[0] = (diag_flags_in & 16'hFFF7) | {12'h000, err, 3'h0};
    for (int n = 1; n < 13; n++) begin
      v = ax((n - 1) ^ 1);
      e[n] = v[15:0];
    end
    e[13] = sample_in.fill;
    e[14] = 16'h0000;
    for (int n = 0; n < 13; n++) e[14] = bsum(e[14], e[n]);
    xf({1'b0, ADDR_BURST, 8'h00});
    for (int n = 0; n < 15; n++) begin
      xf(16'h8000);
      chk16(rx, e[n]);
      if (n < 14) acc = bsum(acc, e[n]);
    end
  endtask : burst_check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // watchdog, about twice the expected run of the sequence below
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    sample_tick = 1'b0;
    set_sample(32'h1020_3040, 16'h1230);
    repeat (3) @(negedge ref_clk);
    chk1(spi_dout, 1'b0);
    chk1(spi_dout_oe_n, 1'b1);
    chk1(spi_error_flag, 1'b0);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    $display("test reset done");

    // every axis half read in one frame, then the running sum
    tick();
    sti_host_model_inst.select(1'b1);
    chk1(spi_dout_oe_n, 1'b0);
    for (int i = 0; i < 13; i++) begin
      w = (i < 12) ? ax(i) : 32'h8000_0000;
      xf(w[31:16]);
      if (i > 0) begin
        w = ax(i - 1);
        chk16(rx, w[15:0]);
        acc = bsum(acc, w[15:0]);
      end
    end
    read_sum(acc);
    sti_host_model_inst.select(1'b0);
    $display("test axis pairs done");

    // short frame flags an error
    sti_host_model_inst.select(1'b1);
    sti_host_model_inst.shift(7, 16'h8000, rx);
    sti_host_model_inst.select(1'b0);
    repeat (8) @(negedge ref_clk);
    chk1(spi_error_flag, 1'b1);
    $display("test framing error done");

    // burst: diag carries the error, checksum skips the fill count
    tick();
    sti_host_model_inst.select(1'b1);
    burst_check(1'b1);
    sti_host_model_inst.select(1'b0);
    repeat (8) @(negedge ref_clk);
    chk1(spi_error_flag, 1'b0);
    sti_host_model_inst.select(1'b1);
    read_sum(acc);
    sti_host_model_inst.select(1'b0);
    $display("test burst done");

    // new period clears the sum; all-ones data makes it wrap
    set_sample(32'hFFFF_FFFF, 16'hA5AF);
    tick();
    sti_host_model_inst.select(1'b1);
    read_sum(16'h0000);
    for (int i = 0; i < 129; i++) begin
      xf({1'b0, ADDR_RATE_LOW0, 8'h00});
      acc = bsum(acc, 16'hFFFF);
    end
    // last answer goes out with the sum command and must be in it
    read_sum(acc);
    // new snapshot and live diag bits, bit 3 overridden by the flag
    burst_check(1'b0);
    read_sum(acc);
    sti_host_model_inst.select(1'b0);
    chk1(spi_dout_oe_n, 1'b1);
    $display("test sum wrap done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
